// *** core/output_mixer_control_regs.sv ***
// output mixer, driver enable and zero-cross timeout control registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - with zero-cross on and no crossing, pending gain applies on the next slow tick, within 2^21 clocks.
// - timeout counter runs only while slow_tick_enable (extra_control bit 0) is set.
// - one slow tick serves both jack debounce and zero-cross timeout.
// - mono mix selects DAC bit0, bypass bit1, second mic bit2, reset 0.
// - bypass_attenuation bit2 gives -10dB on bypass into mono mixer.
// - mono_mix_control bit6 mutes mono output to mid-supply reference.
// - mono driver enabled only while power_control_three bit7 is set.
// - all output enables reset to 0; 1 means on.
// - power_control_three holds speaker/mono mixer and speaker pos/neg enables.
// - power_control_one holds tie-off buffer, amp bias, level-shift driver enables.
module output_mixer_control_regs
#(
    parameter int TIMEOUT_CYCLES = output_mixer_pkg::TIMEOUT_PERIODS
)
(
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  wr_valid,
    input  wire logic [output_mixer_pkg::ADDR_W-1:0]   wr_addr,
    input  wire logic [output_mixer_pkg::DATA_W-1:0]   wr_data,
    input  wire logic                                  gain_pending,
    input  wire logic                                  zero_cross_seen,
    output var  logic                                  gain_apply,
    output var  logic                                  slow_tick,
    output var  logic                                  tieoff_buffer_enable,
    output var  logic                                  amp_bias_enable,
    output var  logic                                  level_shift_driver_enable,
    output var  logic                                  speaker_mixer_enable,
    output var  logic                                  mono_mixer_enable,
    output var  logic                                  speaker_pos_enable,
    output var  logic                                  speaker_neg_enable,
    output var  logic                                  mono_driver_enable,
    output var  logic                                  slow_tick_enable,
    output var  logic                                  speaker_bypass_atten,
    output var  logic                                  mono_bypass_atten,
    output var  logic                                  dac_to_mono_sel,
    output var  logic                                  bypass_to_mono_sel,
    output var  logic                                  second_mic_to_mono_sel,
    output var  logic                                  mono_out_mute
);
    import output_mixer_pkg::*;

    localparam int CNT_W = $clog2(TIMEOUT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
    localparam logic [CNT_W:0]   GAP_FULL = (CNT_W+1)'(TIMEOUT_CYCLES);

    typedef struct packed {
        logic [8:0]       power_one;
        logic [8:0]       power_three;
        logic [8:0]       extra;
        logic [8:0]       bypass_att;
        logic [8:0]       mono_mix;
        logic [CNT_W-1:0] slow_cnt;
        logic             tick;
        logic             apply;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next       = state_reg;
        state_next.tick  = 1'b0;
        state_next.apply = 1'b0;
        // writes land in one cycle so the analogue side sees them at once
        if (wr_valid)
        begin
            if (wr_addr == ADDR_POWER_ONE)
            begin
                state_next.power_one = wr_data;
            end
            else if (wr_addr == ADDR_POWER_THREE)
            begin
                state_next.power_three = wr_data;
            end
            else if (wr_addr == ADDR_EXTRA)
            begin
                state_next.extra = wr_data;
            end
            else if (wr_addr == ADDR_BYPASS_ATT)
            begin
                state_next.bypass_att = wr_data;
            end
            else if (wr_addr == ADDR_MONO_MIX)
            begin
                state_next.mono_mix = wr_data;
            end
        end
        // the divider is held at zero while disabled so the first tick
        // after enabling comes a full period later
        if (!state_reg.extra[BIT_SLOW_TICK])
        begin
            state_next.slow_cnt = '0;
        end
        else if (state_reg.slow_cnt == CNT_LAST)
        begin
            state_next.slow_cnt = '0;
            state_next.tick     = 1'b1;
        end
        else
        begin
            state_next.slow_cnt = state_reg.slow_cnt + CNT_W'(1);
        end
        // a timeout waits at most one slow period, as the tick is shared
        state_next.apply = gain_pending & (zero_cross_seen | state_next.tick);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg.power_one   <= REG_RESET;
            state_reg.power_three <= REG_RESET;
            state_reg.extra       <= REG_RESET;
            state_reg.bypass_att  <= REG_RESET;
            state_reg.mono_mix    <= REG_RESET;
            state_reg.slow_cnt    <= '0;
            state_reg.tick        <= 1'b0;
            state_reg.apply       <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        gain_apply                = state_reg.apply;
        slow_tick                 = state_reg.tick;
        tieoff_buffer_enable      = state_reg.power_one[BIT_TIEOFF_BUF];
        amp_bias_enable           = state_reg.power_one[BIT_AMP_BIAS];
        level_shift_driver_enable = state_reg.power_one[BIT_LEVEL_SHIFT];
        speaker_mixer_enable      = state_reg.power_three[BIT_SPK_MIXER];
        mono_mixer_enable         = state_reg.power_three[BIT_MONO_MIXER];
        speaker_pos_enable        = state_reg.power_three[BIT_SPK_POS];
        speaker_neg_enable        = state_reg.power_three[BIT_SPK_NEG];
        mono_driver_enable        = state_reg.power_three[BIT_MONO_DRIVER];
        slow_tick_enable          = state_reg.extra[BIT_SLOW_TICK];
        speaker_bypass_atten      = state_reg.bypass_att[BIT_SPK_ATTEN];
        mono_bypass_atten         = state_reg.bypass_att[BIT_MONO_ATTEN];
        dac_to_mono_sel           = state_reg.mono_mix[BIT_DAC_MONO];
        bypass_to_mono_sel        = state_reg.mono_mix[BIT_BYP_MONO];
        second_mic_to_mono_sel    = state_reg.mono_mix[BIT_SECOND_MICROPHONE_MONO];
        mono_out_mute             = state_reg.mono_mix[BIT_MONO_MUTE];
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_write(logic [6:0] a);
        wr_valid && wr_addr == a;
    endsequence

    a_mono_enable_write: assert property (s_write(ADDR_POWER_THREE) |=>
        mono_driver_enable == $past(wr_data[BIT_MONO_DRIVER]))
        else $error("mono driver enable did not follow write");
    a_spk_enables: assert property (s_write(ADDR_POWER_THREE) |=>
        {speaker_neg_enable, speaker_pos_enable, mono_mixer_enable, speaker_mixer_enable} ==
        {$past(wr_data[6]), $past(wr_data[5]), $past(wr_data[3]), $past(wr_data[2])})
        else $error("power three enables wrong");
    a_power_one_bits: assert property (s_write(ADDR_POWER_ONE) |=>
        {level_shift_driver_enable, amp_bias_enable, tieoff_buffer_enable} ==
        {$past(wr_data[8]), $past(wr_data[3]), $past(wr_data[2])})
        else $error("power one enables wrong");
    a_mono_select: assert property (s_write(ADDR_MONO_MIX) |=>
        {second_mic_to_mono_sel, bypass_to_mono_sel, dac_to_mono_sel} == $past(wr_data[2:0]))
        else $error("mono source selects wrong");
    a_mono_mute: assert property (s_write(ADDR_MONO_MIX) |=>
        mono_out_mute == $past(wr_data[BIT_MONO_MUTE]))
        else $error("mono mute wrong");
    a_bypass_atten: assert property (s_write(ADDR_BYPASS_ATT) |=>
        mono_bypass_atten == $past(wr_data[BIT_MONO_ATTEN]))
        else $error("mono bypass attenuation wrong");
    a_enables_hold: assert property (!(wr_valid && wr_addr == ADDR_POWER_THREE) |=>
        $stable(mono_driver_enable))
        else $error("enable changed without write");
    // a tick is launched from the enable of the cycle before it, so a clear
    // landing with the tick must not count as a tick while disabled
    a_tick_needs_en: assert property (slow_tick |-> $past(slow_tick_enable) && $past(slow_tick_enable, 2))
        else $error("slow tick while disabled");
    a_tick_spacing: assert property (slow_tick |=> !slow_tick)
        else $error("slow ticks back to back");
    a_apply_cause: assert property (gain_apply |->
        $past(gain_pending) && ($past(zero_cross_seen) || slow_tick))
        else $error("gain applied without cause");
    a_reset_clear: assert property ($past(rst) |-> !mono_driver_enable && !speaker_pos_enable
        && !tieoff_buffer_enable && !slow_tick_enable)
        else $error("enable not cleared by reset");
    a_spk_atten: assert property (s_write(ADDR_BYPASS_ATT) |=>
        speaker_bypass_atten == $past(wr_data[BIT_SPK_ATTEN]))
        else $error("speaker bypass attenuation wrong");
    a_slow_en_write: assert property (s_write(ADDR_EXTRA) |=>
        slow_tick_enable == $past(wr_data[BIT_SLOW_TICK]))
        else $error("slow tick enable did not follow write");

    sequence s_pending_tick;
        gain_pending ##1 slow_tick;
    endsequence

    sequence s_pending_cross;
        gain_pending && zero_cross_seen;
    endsequence

    a_timeout_apply: assert property (s_pending_tick |-> gain_apply)
        else $error("timeout did not apply pending gain");
    a_cross_apply: assert property (s_pending_cross |=> gain_apply)
        else $error("zero crossing did not apply pending gain");

    ////////////////////////////////////////////////////////////////////////////
    // cycles since the enable appeared or the last tick, kept apart from
    // the divider so the period check does not lean on the logic it checks
    logic [CNT_W:0] gap_cnt;

    always_ff @(posedge clk)
    begin
        if (rst || !slow_tick_enable)
        begin
            gap_cnt <= '0;
        end
        else if (slow_tick)
        begin
            gap_cnt <= (CNT_W+1)'(1);
        end
        else
        begin
            gap_cnt <= gap_cnt + (CNT_W+1)'(1);
        end
    end

    a_tick_period: assert property (slow_tick |-> gap_cnt == GAP_FULL)
        else $error("slow tick period wrong");
    a_tick_overdue: assert property (gap_cnt <= GAP_FULL)
        else $error("slow tick overdue");
endmodule

`default_nettype wire

// *** core/output_mixer_pkg.sv ***
// constants for the output mixer control register bank
package output_mixer_pkg;
    localparam int          ADDR_W           = 7;
    localparam int          DATA_W           = 9;
    // register addresses on the control port
    localparam logic [6:0]  ADDR_POWER_ONE   = 7'h01;
    localparam logic [6:0]  ADDR_POWER_THREE = 7'h03;
    localparam logic [6:0]  ADDR_EXTRA       = 7'h07;
    localparam logic [6:0]  ADDR_BYPASS_ATT  = 7'h28;
    localparam logic [6:0]  ADDR_MONO_MIX    = 7'h38;
    // field positions
    localparam int          BIT_TIEOFF_BUF   = 2;
    localparam int          BIT_AMP_BIAS     = 3;
    localparam int          BIT_LEVEL_SHIFT  = 8;
    localparam int          BIT_SPK_MIXER    = 2;
    localparam int          BIT_MONO_MIXER   = 3;
    localparam int          BIT_SPK_POS      = 5;
    localparam int          BIT_SPK_NEG      = 6;
    localparam int          BIT_MONO_DRIVER  = 7;
    localparam int          BIT_SLOW_TICK    = 0;
    localparam int          BIT_SPK_ATTEN    = 1;
    localparam int          BIT_MONO_ATTEN   = 2;
    localparam int          BIT_DAC_MONO     = 0;
    localparam int          BIT_BYP_MONO     = 1;
    localparam int          BIT_SECOND_MICROPHONE_MONO    = 2;
    localparam int          BIT_MONO_MUTE    = 6;
    // reset value of every control bit held here
    localparam logic [8:0]  REG_RESET        = 9'h000;
    // zero-cross timeout, in input clock periods
    localparam int          TIMEOUT_PERIODS  = 2 ** 21;
endpackage

// *** sim/tb.sv ***
// self-checking bench for the output mixer control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import output_mixer_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr_valid = 1'b0;
    logic [6:0]  wr_addr = 7'h00;
    logic [8:0]  wr_data = 9'h000;
    logic        gain_pending = 1'b0;
    logic        zero_cross_seen = 1'b0;
    logic        gain_apply;
    logic        slow_tick;
    logic [14:0] outs;
    int          error_cnt = 0;
    int          checked = 0;
    int          n;
    // index of each output in outs, mute at 0 up to tie-off buffer at 14
    logic [6:0]  addr_tab [15] = '{ADDR_MONO_MIX, ADDR_MONO_MIX, ADDR_MONO_MIX, ADDR_MONO_MIX, ADDR_BYPASS_ATT,
        ADDR_BYPASS_ATT, ADDR_EXTRA, ADDR_POWER_THREE, ADDR_POWER_THREE, ADDR_POWER_THREE, ADDR_POWER_THREE,
        ADDR_POWER_THREE, ADDR_POWER_ONE, ADDR_POWER_ONE, ADDR_POWER_ONE};
    int          bit_tab [15] = '{BIT_MONO_MUTE, BIT_SECOND_MICROPHONE_MONO, BIT_BYP_MONO, BIT_DAC_MONO, BIT_MONO_ATTEN,
        BIT_SPK_ATTEN, BIT_SLOW_TICK, BIT_MONO_DRIVER, BIT_SPK_NEG, BIT_SPK_POS, BIT_MONO_MIXER,
        BIT_SPK_MIXER, BIT_LEVEL_SHIFT, BIT_AMP_BIAS, BIT_TIEOFF_BUF};
    always #2.5 clk = ~clk;
    output_mixer_control_regs #(.TIMEOUT_CYCLES(16)) i_output_mixer_control_regs (
        .clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .gain_pending(gain_pending), .zero_cross_seen(zero_cross_seen), .gain_apply(gain_apply),
        .slow_tick(slow_tick), .tieoff_buffer_enable(outs[14]), .amp_bias_enable(outs[13]),
        .level_shift_driver_enable(outs[12]), .speaker_mixer_enable(outs[11]), .mono_mixer_enable(outs[10]),
        .speaker_pos_enable(outs[9]), .speaker_neg_enable(outs[8]), .mono_driver_enable(outs[7]),
        .slow_tick_enable(outs[6]), .speaker_bypass_atten(outs[5]), .mono_bypass_atten(outs[4]),
        .dac_to_mono_sel(outs[3]), .bypass_to_mono_sel(outs[2]), .second_mic_to_mono_sel(outs[1]),
        .mono_out_mute(outs[0]));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [14:0] got, input logic [14:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
            error_cnt++;
        end
    endtask
    // one-cycle strobe; outputs have settled by the falling edge on return
    task automatic reg_write(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_addr  = a;
        wr_data  = d;
        @(negedge clk);
        wr_valid = 1'b0;
        wr_data  = ~d;
    endtask
    // counts falling edges up to the next slow tick, bounded at 100
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do
        begin
            @(negedge clk);
            cnt++;
        end
        while (slow_tick !== 1'b1 && cnt < 100);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #50000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        check(outs, 15'h0000, "reset values");
        for (int i = 0; i < 15; i++)
        begin
            reg_write(addr_tab[i], 9'h001 << bit_tab[i]);
            check(outs, 15'h0001 << i, "single field");
            reg_write(addr_tab[i], 9'h000);
            check(outs, 15'h0000, "field cleared");
        end
        reg_write(7'h02, 9'h1FF);
        check(outs, 15'h0000, "unmapped write");
        reg_write(ADDR_EXTRA, 9'h001);
        wait_tick(n);
        check(15'(n < 20), 15'h0001, "first tick");
        check(15'(gain_apply), 15'h0000, "no apply without pending");
        gain_pending = 1'b1;
        wait_tick(n);
        check(15'(n), 15'h0010, "tick period");
        check(15'(gain_apply), 15'h0001, "timeout apply");
        gain_pending = 1'b0;
        reg_write(ADDR_EXTRA, 9'h000);
        wait_tick(n);
        check(15'(n), 15'h0064, "no tick when disabled");
        gain_pending = 1'b1;
        zero_cross_seen = 1'b1;
        @(negedge clk);
        check(15'(gain_apply), 15'h0001, "zero cross apply");
        gain_pending = 1'b0;
        zero_cross_seen = 1'b0;
        reg_write(ADDR_POWER_ONE, 9'h1FF);
        reg_write(ADDR_POWER_THREE, 9'h1FF);
        reg_write(ADDR_BYPASS_ATT, 9'h1FF);
        reg_write(ADDR_MONO_MIX, 9'h1FF);
        check(outs, 15'h7FBF, "all set");
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check(outs, 15'h0000, "mid-run reset");
        close_out();
    end
endmodule
`default_nettype wire
